//--- hdl/dpw_cfg.svh
// Shared constants for the dual wiper serial slave
// Assumes it is included by bare name before any use
`ifndef DPW_CFG_SVH
`define DPW_CFG_SVH

// Sizes
`define DPW_POTS 2
`define DPW_SLOTS 4
`define DPW_POS_W 6

// Reset and power-up values
`define DPW_STORE_INIT 6'h20
`define DPW_WIP_RST 6'h00
`define DPW_LINE_IDLE 2'h3

// Address byte: type code, four straps, read bit
`define DPW_TYPE_ID 3'h5
`define DPW_TYPE_HI 7
`define DPW_TYPE_LO 5
`define DPW_STRAP_HI 4
`define DPW_STRAP_LO 1
`define DPW_RW_BIT 0

// Instruction byte: opcode, slot, pot
`define DPW_OP_HI 7
`define DPW_OP_LO 4
`define DPW_SLOT_HI 3
`define DPW_SLOT_LO 2
`define DPW_POT_BIT 0
`define DPW_STEP_BIT 0
`define DPW_LAST_BIT 3'h7

// Opcodes
`define DPW_OP_RD_WIP 4'h9
`define DPW_OP_WR_WIP 4'hA
`define DPW_OP_RD_STO 4'hB
`define DPW_OP_WR_STO 4'hC
`define DPW_OP_TO_WIP 4'hD
`define DPW_OP_TO_STO 4'hE
`define DPW_OP_STEP 4'h2
`endif

//--- hdl/dpw_pkg.sv
// Types shared by the dual wiper serial slave
// Assumes dpw_cfg.svh is on the include path
`include "dpw_cfg.svh"
package dpw_pkg;
  // Serial engine states, one-hot
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ACK_A = 9'h004,
    ST_INSTR = 9'h008,
    ST_ACK_I = 9'h010,
    ST_DATA = 9'h020,
    ST_ACK_D = 9'h040,
    ST_SEND = 9'h080,
    ST_ACK_M = 9'h100
  } dpw_state_e;
  // Instruction opcode
  typedef logic [3:0] dpw_op_t;
endpackage

//--- hdl/dpw_line_edge.sv
// Samples the serial clock and data lines and flags their events
// Assumes both lines are synchronous to the system clock
`timescale 1ns/1ns
`include "dpw_cfg.svh"
module dpw_line_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  output logic scl_lv,
  output logic sda_lv,
  output logic scl_rise,
  output logic scl_fall,
  output logic start,
  output logic stop
);
  logic [1:0] cur_q, cur_d, old_q, old_d;

  // Next samples: pins now and one cycle back
  always_comb begin
    cur_d = {scl, sda};
    old_d = cur_q;
  end

  // Sample registers, lines idle high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_q <= `DPW_LINE_IDLE;
      old_q <= `DPW_LINE_IDLE;
    end else begin
      cur_q <= cur_d;
      old_q <= old_d;
    end
  end

  // Clock edges, and data moving while clock stays high
  assign scl_lv = cur_q[1];
  assign sda_lv = cur_q[0];
  assign scl_rise = cur_q[1] & ~old_q[1];
  assign scl_fall = ~cur_q[1] & old_q[1];
  assign start = cur_q[1] & old_q[1] & old_q[0] & ~cur_q[0];
  assign stop = cur_q[1] & old_q[1] & ~old_q[0] & cur_q[0];
endmodule

//--- hdl/dpw_store.sv
// Wiper registers and nonvolatile stored settings with power-up recall
// Assumes one write strobe at a time from the serial engine
`timescale 1ns/1ns
`include "dpw_cfg.svh"
module dpw_store #(
  parameter int POTS = `DPW_POTS,
  parameter int SLOTS = `DPW_SLOTS,
  parameter int W = `DPW_POS_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wp_n,
  input wire logic wr_wip,
  input wire logic wr_sto,
  input wire logic [$clog2(POTS)-1:0] pot,
  input wire logic [$clog2(SLOTS)-1:0] slot,
  input wire logic [W-1:0] wdata,
  output logic [POTS-1:0][W-1:0] wip_q,
  output logic [W-1:0] sto_rd
);
  localparam int AW = $clog2(POTS * SLOTS);
  logic [W-1:0] mem_q [POTS*SLOTS] = '{default: `DPW_STORE_INIT};
  logic [W-1:0] mem_d [POTS*SLOTS];
  logic [POTS-1:0][W-1:0] wip_d;
  logic rcl_q, rcl_d;
  logic [AW-1:0] addr;

  // Flat slot index of the selected pot
  assign addr = AW'(pot * SLOTS + slot);
  assign sto_rd = mem_q[addr];

  // Next wiper and stored values
  always_comb begin
    wip_d = wip_q;
    mem_d = mem_q;
    rcl_d = 1'b0;
    if (rcl_q) begin
      for (int p = 0; p < POTS; p++) begin
        wip_d[p] = mem_q[p * SLOTS];
      end
    end else if (wr_wip) begin
      wip_d[pot] = wdata;
    end
    if (wr_sto && wp_n) begin
      mem_d[addr] = wdata;
    end
  end

  // Wiper registers, recall armed by reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wip_q <= {POTS{`DPW_WIP_RST}};
      rcl_q <= 1'b1;
    end else begin
      wip_q <= wip_d;
      rcl_q <= rcl_d;
    end
  end

  // Stored settings survive reset
  always_ff @(posedge clk) begin
    mem_q <= mem_d;
  end

  default clocking dcb @(posedge clk); endclocking
  default disable iff (rst);

  recall_load_a:
    assert property (rcl_q |=> !rcl_q && wip_q[0] == mem_q[0] && wip_q[1] == mem_q[SLOTS])
    else $error("stored setting 0 not recalled into wiper");
  wp_block_a:
    assert property (!wp_n |=> mem_q[$past(addr)] == $past(sto_rd))
    else $error("stored setting changed while protected");
  sto_write_a:
    assert property (wr_sto && wp_n |=> mem_q[$past(addr)] == $past(wdata))
    else $error("stored setting write lost");
  wip_own_a:
    assert property (wr_wip && !rcl_q && pot == '0
      |=> wip_q[0] == $past(wdata) && $stable(wip_q[1]))
    else $error("wiper write wrong or touched other pot");
endmodule

//--- hdl/dpw_wiper_slave.sv
// Top of the dual wiper serial slave: two-wire engine and command decoder
// Assumes SCL and SDA_IN are synchronous and each bus phase lasts 2+ cycles
`timescale 1ns/1ns
`include "dpw_cfg.svh"
module dpw_wiper_slave #(
  parameter int POS_W = `DPW_POS_W
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic ADDR_STRAP_0,
  input wire logic ADDR_STRAP_1,
  input wire logic ADDR_STRAP_2,
  input wire logic ADDR_STRAP_3,
  input wire logic WP_N,
  output logic [POS_W-1:0] WIPER_POS_0,
  output logic [POS_W-1:0] WIPER_POS_1,
  output logic [(1<<POS_W)-1:0] TAP_SEL_0,
  output logic [(1<<POS_W)-1:0] TAP_SEL_1
);
  localparam int POTS = `DPW_POTS;
  localparam int SLOTS = `DPW_SLOTS;
  localparam int SW = $clog2(SLOTS);
  localparam int TAPS = 1 << POS_W;

  // One-hot tap select from a wiper position
  function automatic logic [TAPS-1:0] pos_hot(input logic [POS_W-1:0] pos);
    logic [TAPS-1:0] hot;
    hot = '0;
    hot[pos] = 1'b1;
    return hot;
  endfunction

  // Whether a byte of this opcode earns an acknowledge
  function automatic logic op_ack(input dpw_pkg::dpw_op_t op, input logic wpn,
                                  input logic dat);
    logic nv;
    nv = (op == `DPW_OP_WR_STO) || (op == `DPW_OP_TO_STO);
    if (nv && !wpn) begin
      return 1'b0;
    end
    if (dat) begin
      return (op == `DPW_OP_WR_WIP) || (op == `DPW_OP_WR_STO) || (op == `DPW_OP_STEP);
    end
    return (op == `DPW_OP_RD_WIP) || (op == `DPW_OP_WR_WIP) || (op == `DPW_OP_RD_STO) ||
           (op == `DPW_OP_WR_STO) || (op == `DPW_OP_TO_WIP) || (op == `DPW_OP_TO_STO) ||
           (op == `DPW_OP_STEP);
  endfunction

  dpw_pkg::dpw_state_e st_q, st_d;
  dpw_pkg::dpw_op_t op_q, op_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic oe_q, oe_d;
  logic drv_q, drv_d;
  logic ok_q, ok_d;
  logic rw_q, rw_d;
  logic rds_q, rds_d;
  logic pot_q, pot_d;
  logic [SW-1:0] slot_q, slot_d;
  logic wr_wip, wr_sto;
  logic [POS_W-1:0] wdata, sto_rd, wip_cur, step;
  logic [POTS-1:0][POS_W-1:0] wip_all;
  logic [POTS-1:0][TAPS-1:0] tap_q, tap_d;
  logic [7:0] rx, rbyte;
  logic [3:0] straps;
  logic scl_lv, sda_lv, scl_rise, scl_fall, start, stop;
  logic in_ack, ack_edge;

  // Line sampler and event flags
  dpw_line_edge u_edge (
    .clk(CLK_SYS),
    .rst(RST),
    .scl(SCL),
    .sda(SDA_IN),
    .scl_lv(scl_lv),
    .sda_lv(sda_lv),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start(start),
    .stop(stop)
  );

  // Wiper registers and stored settings
  dpw_store #(
    .POTS(POTS),
    .SLOTS(SLOTS),
    .W(POS_W)
  ) u_store (
    .clk(CLK_SYS),
    .rst(RST),
    .wp_n(WP_N),
    .wr_wip(wr_wip),
    .wr_sto(wr_sto),
    .pot(pot_q),
    .slot(slot_q),
    .wdata(wdata),
    .wip_q(wip_all),
    .sto_rd(sto_rd)
  );

  // Straps form the address, strap 0 lowest
  assign straps = {ADDR_STRAP_3, ADDR_STRAP_2, ADDR_STRAP_1, ADDR_STRAP_0};
  assign rx = {sh_q[6:0], sda_lv};
  assign wip_cur = wip_all[pot_q];
  assign rbyte = 8'(rds_q ? sto_rd : wip_cur);
  assign in_ack = (st_q == dpw_pkg::ST_ACK_A) || (st_q == dpw_pkg::ST_ACK_I) ||
                  (st_q == dpw_pkg::ST_ACK_D);
  assign ack_edge = in_ack && !drv_q && scl_fall;

  // Saturating one-tap step, bit 0 of the data byte picks direction
  assign step = sh_q[`DPW_STEP_BIT] ?
                ((wip_cur == {POS_W{1'b1}}) ? wip_cur : wip_cur + 1'b1) :
                ((wip_cur == '0) ? wip_cur : wip_cur - 1'b1);

  // Serial engine: next state, shifter and register strobes
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    oe_d = oe_q;
    drv_d = drv_q;
    ok_d = ok_q;
    rw_d = rw_q;
    rds_d = rds_q;
    op_d = op_q;
    pot_d = pot_q;
    slot_d = slot_q;
    wr_wip = 1'b0;
    wr_sto = 1'b0;
    wdata = sh_q[POS_W-1:0];
    if (stop) begin
      st_d = dpw_pkg::ST_IDLE;
      oe_d = 1'b0;
      drv_d = 1'b0;
    end else if (start) begin
      st_d = dpw_pkg::ST_ADDR;
      cnt_d = '0;
      oe_d = 1'b0;
      drv_d = 1'b0;
    end else begin
      case (st_q)
        dpw_pkg::ST_ADDR, dpw_pkg::ST_INSTR, dpw_pkg::ST_DATA: begin
          // Data bits are taken on the rising serial clock
          if (scl_rise) begin
            sh_d = rx;
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == `DPW_LAST_BIT) begin
              if (st_q == dpw_pkg::ST_ADDR) begin
                ok_d = (rx[`DPW_TYPE_HI:`DPW_TYPE_LO] == `DPW_TYPE_ID) &&
                       (rx[`DPW_STRAP_HI:`DPW_STRAP_LO] == straps);
                rw_d = rx[`DPW_RW_BIT];
                st_d = dpw_pkg::ST_ACK_A;
              end else if (st_q == dpw_pkg::ST_INSTR) begin
                op_d = rx[`DPW_OP_HI:`DPW_OP_LO];
                slot_d = rx[`DPW_SLOT_HI:`DPW_SLOT_LO];
                pot_d = rx[`DPW_POT_BIT];
                ok_d = op_ack(rx[`DPW_OP_HI:`DPW_OP_LO], WP_N, 1'b0);
                st_d = dpw_pkg::ST_ACK_I;
              end else begin
                ok_d = op_ack(op_q, WP_N, 1'b1);
                st_d = dpw_pkg::ST_ACK_D;
              end
            end
          end
        end
        dpw_pkg::ST_ACK_A, dpw_pkg::ST_ACK_I, dpw_pkg::ST_ACK_D: begin
          if (scl_fall && !drv_q) begin
            // Open the acknowledge slot and carry out the byte
            drv_d = 1'b1;
            oe_d = ok_q;
            if (ok_q && st_q == dpw_pkg::ST_ACK_I) begin
              case (op_q)
                `DPW_OP_RD_WIP: begin
                  rds_d = 1'b0;
                end
                `DPW_OP_RD_STO: begin
                  rds_d = 1'b1;
                end
                `DPW_OP_TO_WIP: begin
                  wr_wip = 1'b1;
                  wdata = sto_rd;
                end
                `DPW_OP_TO_STO: begin
                  wr_sto = 1'b1;
                  wdata = wip_cur;
                end
                default: begin
                end
              endcase
            end
            if (ok_q && st_q == dpw_pkg::ST_ACK_D) begin
              if (op_q == `DPW_OP_WR_WIP) begin
                wr_wip = 1'b1;
              end else if (op_q == `DPW_OP_WR_STO) begin
                wr_sto = 1'b1;
              end else if (op_q == `DPW_OP_STEP) begin
                wr_wip = 1'b1;
                wdata = step;
              end
            end
          end else if (scl_fall) begin
            // Close the slot; a refused byte drops the transfer
            drv_d = 1'b0;
            oe_d = 1'b0;
            cnt_d = '0;
            if (!ok_q) begin
              st_d = dpw_pkg::ST_IDLE;
            end else if (st_q == dpw_pkg::ST_ACK_A && rw_q) begin
              st_d = dpw_pkg::ST_SEND;
              sh_d = rbyte;
              oe_d = ~rbyte[7];
            end else if (st_q == dpw_pkg::ST_ACK_A) begin
              st_d = dpw_pkg::ST_INSTR;
            end else begin
              st_d = dpw_pkg::ST_DATA;
            end
          end
        end
        dpw_pkg::ST_SEND: begin
          // Next bit goes out while the serial clock is low
          if (scl_fall) begin
            if (cnt_q == `DPW_LAST_BIT) begin
              oe_d = 1'b0;
              cnt_d = '0;
              st_d = dpw_pkg::ST_ACK_M;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
              cnt_d = cnt_q + 3'h1;
            end
          end
        end
        dpw_pkg::ST_ACK_M: begin
          // Master acknowledge asks for the same register again
          if (scl_rise) begin
            ok_d = ~sda_lv;
          end else if (scl_fall) begin
            if (ok_q) begin
              st_d = dpw_pkg::ST_SEND;
              sh_d = rbyte;
              oe_d = ~rbyte[7];
            end else begin
              st_d = dpw_pkg::ST_IDLE;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Serial engine registers
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_q <= dpw_pkg::ST_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      oe_q <= 1'b0;
      drv_q <= 1'b0;
      ok_q <= 1'b0;
      rw_q <= 1'b0;
      rds_q <= 1'b0;
      op_q <= '0;
      pot_q <= 1'b0;
      slot_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      oe_q <= oe_d;
      drv_q <= drv_d;
      ok_q <= ok_d;
      rw_q <= rw_d;
      rds_q <= rds_d;
      op_q <= op_d;
      pot_q <= pot_d;
      slot_q <= slot_d;
    end
  end

  // Tap decode for every pot
  always_comb begin
    for (int p = 0; p < POTS; p++) begin
      tap_d[p] = pos_hot(wip_all[p]);
    end
  end

  // Tap select registers, tap 0 matches wiper reset
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      tap_q <= {POTS{{{(TAPS-1){1'b0}}, 1'b1}}};
    end else begin
      tap_q <= tap_d;
    end
  end

  // Data pin only ever pulls low
  assign SDA_OUT = 1'b0;
  assign SDA_OE = oe_q;
  assign WIPER_POS_0 = wip_all[0];
  assign WIPER_POS_1 = wip_all[1];
  assign TAP_SEL_0 = tap_q[0];
  assign TAP_SEL_1 = tap_q[1];

  default clocking dcb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence addr_last_s;
    st_q == dpw_pkg::ST_ADDR && scl_rise && cnt_q == `DPW_LAST_BIT;
  endsequence
  sequence ack_open_s;
    in_ack && !drv_q && scl_fall;
  endsequence

  tap_hot_a:
    assert property ($onehot(tap_q[0]) && $onehot(tap_q[1]))
    else $error("tap select not one-hot");
  tap_follow_a:
    assert property (1'b1 |=> TAP_SEL_0 == pos_hot($past(WIPER_POS_0)))
    else $error("tap select does not follow wiper");
  sda_drive_a:
    assert property (SDA_OE |-> in_ack || st_q == dpw_pkg::ST_SEND)
    else $error("data pulled low outside ack or send");
  oe_scl_low_a:
    assert property ($rose(SDA_OE) |-> !scl_lv)
    else $error("data pulled low while clock high");
  addr_match_a:
    assert property (addr_last_s |=> ok_q == (sh_q[`DPW_STRAP_HI:`DPW_STRAP_LO] == straps
      && sh_q[`DPW_TYPE_HI:`DPW_TYPE_LO] == `DPW_TYPE_ID))
    else $error("address acknowledge does not match straps");
  ack_drive_a:
    assert property (ack_open_s |=> SDA_OE == $past(ok_q) && drv_q)
    else $error("acknowledge slot driven wrongly");
  start_seen_a:
    assert property (start && !stop |=> st_q == dpw_pkg::ST_ADDR && !SDA_OE)
    else $error("start not followed by address phase");
  step_up_a:
    assert property (ack_edge && st_q == dpw_pkg::ST_ACK_D && ok_q && op_q == `DPW_OP_STEP
      && sh_q[`DPW_STEP_BIT] && !pot_q && WIPER_POS_0 != '1
      ##1 1'b1 |=> WIPER_POS_0 == $past(WIPER_POS_0, 2) + 1'b1)
    else $error("step up did not add one tap");
endmodule

//--- verification/dpw_bus_master.sv
// Two-wire bus master model: makes the serial clock and pulls the data wire low
// Assumes a pull-up resolves the data wire from every party's pull enable
`timescale 1ns/1ns
module dpw_bus_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // Clock stands high and data is released between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Third of a bit time
  task automatic tick();
    repeat (4) @(posedge clk);
  endtask

  // One bit: data set while clock low, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_pull <= ~b;
    tick();
    scl <= 1'b1;
    tick();
    r = sda;
    scl <= 1'b0;
    tick();
  endtask

  // Start or repeated start: data falls while clock high
  task automatic start_c();
    sda_pull <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_pull <= 1'b1;
    tick();
    scl <= 1'b0;
    tick();
  endtask

  // Stop: data rises while clock high, then the bus is left idle
  task automatic stop_c();
    sda_pull <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_pull <= 1'b0;
    tick();
  endtask

  // Byte out MSB first, then the acknowledge slot
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Byte in MSB first; last high means no acknowledge, ending the read
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

//--- verification/dpw_wiper_slave_tb.sv
// Self-checking bench for the dual wiper serial slave
// Assumes dpw_cfg.svh on the include path and the bus master model compiled first
`timescale 1ns/1ns
`include "dpw_cfg.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin $display("Error t=%0t got %0h exp %0h", $time, (got), (exp)); n_mismatch++; end end
module dpw_wiper_slave_tb;
  logic clk_sys;
  logic rst;
  logic [3:0] strap;
  logic wp_n;
  logic scl;
  logic sda_pull;
  logic sda_out;
  logic sda_oe;
  wire logic sda;
  logic [5:0] pos0, pos1;
  logic [63:0] tap0, tap1;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [5:0] wip_m [2];
  logic [5:0] sto_m [2][4];

  // Open-drain wire with pull-up: low while any party pulls
  assign sda = ~(sda_oe | sda_pull);

  dpw_wiper_slave i_dpw_wiper_slave (.CLK_SYS(clk_sys), .RST(rst), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_STRAP_0(strap[0]), .ADDR_STRAP_1(strap[1]),
    .ADDR_STRAP_2(strap[2]), .ADDR_STRAP_3(strap[3]), .WP_N(wp_n), .WIPER_POS_0(pos0),
    .WIPER_POS_1(pos1), .TAP_SEL_0(tap0), .TAP_SEL_1(tap1));

  dpw_bus_master i_dpw_bus_master (.clk(clk_sys), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  // Verdict and end of run
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Instruction byte from opcode, slot and pot
  function automatic logic [7:0] ins(logic [3:0] op, int s, int p);
    return {op, 2'(s), 1'b0, 1'(p)};
  endfunction

  // Expected wiper after n saturating steps
  function automatic logic [5:0] step_exp(logic [5:0] v, logic up, int n);
    for (int i = 0; i < n; i++) begin
      if (up && v != 6'h3F) v++;
      else if (!up && v != 6'h00) v--;
    end
    return v;
  endfunction

  // Write frame: address, instruction, nd data bytes; acks = {addr, instr, last data}
  task automatic cmd(input logic [3:0] a, input logic [7:0] i, input int nd,
                     input logic [7:0] d, output logic [2:0] acks);
    i_dpw_bus_master.start_c();
    i_dpw_bus_master.put_byte({`DPW_TYPE_ID, a, 1'b0}, acks[2]);
    i_dpw_bus_master.put_byte(i, acks[1]);
    acks[0] = 1'b0;
    for (int n = 0; n < nd; n++) i_dpw_bus_master.put_byte(d, acks[0]);
    i_dpw_bus_master.stop_c();
  endtask

  // Read frame with repeated start and one byte back
  task automatic rd(input logic [7:0] i, output logic [7:0] d);
    logic ak;
    i_dpw_bus_master.start_c();
    i_dpw_bus_master.put_byte({`DPW_TYPE_ID, strap, 1'b0}, ak);
    i_dpw_bus_master.put_byte(i, ak);
    i_dpw_bus_master.start_c();
    i_dpw_bus_master.put_byte({`DPW_TYPE_ID, strap, 1'b1}, ak);
    i_dpw_bus_master.get_byte(1'b1, d);
    i_dpw_bus_master.stop_c();
  endtask

  // Both wipers and their one-hot tap selects against the model
  task automatic chk_pots();
    `CHK(pos0, wip_m[0])
    `CHK(pos1, wip_m[1])
    `CHK(tap0, 64'h1 << wip_m[0])
    `CHK(tap1, 64'h1 << wip_m[1])
  endtask

  // System clock, 100 ns period
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Watchdog against a hung run
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    stop_test();
  end

  // Main sequence
  initial begin
    logic [2:0] ak;
    logic [7:0] d;
    logic [5:0] v;
    int p;
    int s;
    rst = 1'b1;
    strap = 4'h0;
    wp_n = 1'b1;
    void'($urandom(32'hAE873BE5));
    for (int i = 0; i < 8; i++) sto_m[i / 4][i % 4] = `DPW_STORE_INIT;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wip_m[0] = sto_m[0][0];
    wip_m[1] = sto_m[1][0];
    chk_pots();
    // Random pots, slots, values and strap patterns
    for (int i = 0; i < 8; i++) begin
      p = $urandom_range(1);
      s = $urandom_range(3);
      v = 6'($urandom);
      strap <= 4'($urandom);
      @(posedge clk_sys);
      cmd(strap, ins(`DPW_OP_WR_WIP, 0, p), 1, {2'h0, v}, ak);
      `CHK(ak, 3'h7)
      wip_m[p] = v;
      chk_pots();
      cmd(strap ^ (4'h1 << (i % 4)), ins(`DPW_OP_WR_WIP, 0, p), 1, 8'h3F, ak);
      `CHK(ak[2], 1'b0)
      chk_pots();
      cmd(strap, ins(`DPW_OP_WR_STO, s, p), 1, {2'h0, ~v}, ak);
      sto_m[p][s] = ~v;
      rd(ins(`DPW_OP_RD_STO, s, p), d);
      `CHK(d[5:0], sto_m[p][s])
      cmd(strap, ins(`DPW_OP_TO_WIP, s, p), 0, 8'h00, ak);
      wip_m[p] = sto_m[p][s];
      chk_pots();
      s = $urandom_range(3);
      cmd(strap, ins(`DPW_OP_WR_WIP, 0, p), 1, {2'h0, v ^ 6'h15}, ak);
      wip_m[p] = v ^ 6'h15;
      cmd(strap, ins(`DPW_OP_TO_STO, s, p), 0, 8'h00, ak);
      sto_m[p][s] = wip_m[p];
      rd(ins(`DPW_OP_RD_STO, s, p), d);
      `CHK(d[5:0], sto_m[p][s])
      rd(ins(`DPW_OP_RD_WIP, 0, p), d);
      `CHK(d[5:0], wip_m[p])
    end
    // Unknown opcode is refused at the instruction byte
    cmd(strap, ins(4'h0, 0, 0), 0, 8'h00, ak);
    `CHK(ak[1], 1'b0)
    // Write protect blocks stored writes but not wiper writes
    wp_n <= 1'b0;
    @(posedge clk_sys);
    cmd(strap, ins(`DPW_OP_WR_STO, 1, 0), 1, 8'h05, ak);
    `CHK(ak[1], 1'b0)
    cmd(strap, ins(`DPW_OP_TO_STO, 1, 0), 0, 8'h00, ak);
    rd(ins(`DPW_OP_RD_STO, 1, 0), d);
    `CHK(d[5:0], sto_m[0][1])
    cmd(strap, ins(`DPW_OP_WR_WIP, 0, 0), 1, 8'h2A, ak);
    `CHK(ak, 3'h7)
    wip_m[0] = 6'h2A;
    chk_pots();
    wp_n <= 1'b1;
    // Step mode saturates at both ends of the travel
    cmd(strap, ins(`DPW_OP_WR_WIP, 0, 0), 1, 8'h3E, ak);
    cmd(strap, ins(`DPW_OP_STEP, 0, 0), 3, 8'h01, ak);
    `CHK(ak, 3'h7)
    wip_m[0] = step_exp(6'h3E, 1'b1, 3);
    chk_pots();
    cmd(strap, ins(`DPW_OP_WR_WIP, 0, 1), 1, 8'h01, ak);
    cmd(strap, ins(`DPW_OP_STEP, 0, 1), 3, 8'h00, ak);
    `CHK(ak, 3'h7)
    wip_m[1] = step_exp(6'h01, 1'b0, 3);
    chk_pots();
    `CHK(sda_out, 1'b0)
    // Second reset recalls slot 0, which keeps its written content
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wip_m[0] = sto_m[0][0];
    wip_m[1] = sto_m[1][0];
    chk_pots();
    stop_test();
  end
endmodule
